/* rtl/psab_pkg.sv */
// psab_pkg: constants and carriers for the async page-mode pseudo-static ram bus
// assumes one 100 MHz clock; pins arrive unsynchronised from the host
package psab_pkg;

	// ---------------------------------------------------------------
	// geometry
	// ---------------------------------------------------------------
	localparam int ADDR_W  = 21;
	localparam int DATA_W  = 16;
	localparam int BYTE_W  = 8;
	localparam int PAGE_W  = 2;
	localparam int MEM_W   = 4;                 // storage depth kept small in flip-flops
	localparam int MEM_D   = 16;

	// ---------------------------------------------------------------
	// mode register fields
	// ---------------------------------------------------------------
	localparam int MS_LO   = 14;
	localparam int MS_HI   = 15;
	localparam int MODE_W  = 18;
	localparam logic [1:0]        MS_ASYNC  = 2'h0;
	localparam logic [MODE_W-1:0] MODE_RST  = 18'h00000;

	// ---------------------------------------------------------------
	// power-up timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ    = 100;
	localparam int PWRUP_US   = 200;
	localparam int PWRUP_CYC  = PWRUP_US * CLK_MHZ;
	localparam int PWR_CNT_W  = 15;

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic chip_select_n;
		logic output_enable_n;
		logic write_enable_n;
		logic lower_byte_enable_n;
		logic upper_byte_enable_n;
		logic address_valid_n;
	} psab_ctl_t;

	typedef enum logic [1:0] {
		PSAB_POWER_UP = 2'b00,
		PSAB_SETTLE   = 2'b01,
		PSAB_READY    = 2'b10
	} psab_pwr_t;

endpackage : psab_pkg

/* rtl/psab_sync.sv */
// psab_sync: two-flop synchroniser for a bundle of pin levels
// assumes the input is asynchronous to clock
`timescale 1ns/1ps
module psab_sync #(
	parameter int W = 1
) (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// first stage is read only by the second
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			meta_reg <= '1;
			q        <= '1;
		end
		else
		begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule : psab_sync

/* rtl/psab_bus.sv */
// psab_bus: device-side pin behaviour of the pseudo-static ram in async mode
// assumes the host drives every control pin to a valid level at all times
`timescale 1ns/1ps
module psab_bus
	import psab_pkg::*;
(
	input  wire logic                clock,
	input  wire logic                rst,
	input  wire psab_ctl_t           ctl_pins,
	input  wire logic [ADDR_W-1:0]   address,
	input  wire logic [DATA_W-1:0]   data_in,
	input  wire logic                link_clock_pin,
	output logic      [DATA_W-1:0]   data_out,
	output logic      [1:0]          data_oe,
	output logic                     wait_out,
	output logic                     wait_oe,
	output logic                     standby,
	output logic                     async_mode,
	output logic                     power_ready
);
	localparam int SW = $bits(psab_ctl_t) + ADDR_W + DATA_W;

	// ---------------------------------------------------------------
	// pin synchronisation
	// ---------------------------------------------------------------
	logic [SW-1:0]       sync_q;
	psab_ctl_t           ctl;
	logic [ADDR_W-1:0]   addr;
	logic [DATA_W-1:0]   din;

	psab_sync #(.W(SW)) u_sync (
		.clock (clock),
		.rst   (rst),
		.d     ({ctl_pins, address, data_in}),
		.q     (sync_q)
	);

	assign ctl  = psab_ctl_t'(sync_q[SW-1 -: $bits(psab_ctl_t)]);
	assign addr = sync_q[DATA_W +: ADDR_W];
	assign din  = sync_q[DATA_W-1:0];

	// clock pin is never looked at; it only exists as a pin
	logic unused_clk;
	assign unused_clk = link_clock_pin;

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	logic sel, rd, wr, mrs_hit;
	logic [1:0] lane_en;

	assign sel     = !ctl.chip_select_n;
	assign lane_en = {!ctl.upper_byte_enable_n, !ctl.lower_byte_enable_n};
	// address valid low turns a both-lane write into a mode write; reads and byte writes ignore it
	assign mrs_hit = sel && !ctl.address_valid_n && !ctl.write_enable_n
		&& ctl.output_enable_n && (lane_en == 2'h3);
	assign rd      = sel && !ctl.output_enable_n && ctl.write_enable_n;
	assign wr      = sel && ctl.output_enable_n && !ctl.write_enable_n && !mrs_hit;

	// ---------------------------------------------------------------
	// mode register
	// ---------------------------------------------------------------
	logic [MODE_W-1:0] mode_reg;
	logic              mrs_d_reg;

	// captured once per low-going strobe so a held strobe writes once
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			mode_reg  <= MODE_RST;
			mrs_d_reg <= 1'b0;
		end
		else
		begin
			mrs_d_reg <= mrs_hit;
			if (mrs_hit && !mrs_d_reg)
				mode_reg <= addr[MODE_W-1:0];
		end
	end

	logic is_async;
	assign is_async = (mode_reg[MS_HI:MS_LO] == MS_ASYNC);

	// ---------------------------------------------------------------
	// power-up tracking
	// ---------------------------------------------------------------
	psab_pwr_t             pwr_reg;
	logic [PWR_CNT_W-1:0]  pwr_cnt_reg;

	// counts select-high time; a low select restarts the wait
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			pwr_reg     <= PSAB_POWER_UP;
			pwr_cnt_reg <= '0;
		end
		else
		begin
			case (pwr_reg)
				PSAB_POWER_UP:
				begin
					if (sel)
						pwr_cnt_reg <= '0;
					else if (pwr_cnt_reg == PWR_CNT_W'(PWRUP_CYC - 1))
						pwr_reg <= PSAB_SETTLE;
					else
						pwr_cnt_reg <= pwr_cnt_reg + 1'b1;
				end
				PSAB_SETTLE:
				begin
					if (sel)
						pwr_reg <= PSAB_READY;
				end
				PSAB_READY: pwr_reg <= PSAB_READY;
				default:    pwr_reg <= PSAB_POWER_UP;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// storage
	// ---------------------------------------------------------------
	logic [DATA_W-1:0] mem_reg [MEM_D];
	logic [MEM_W-1:0]  widx;

	// word index uses the four lowest bits, so page words differ by the two lowest
	assign widx = addr[MEM_W-1:0];

	always_ff @(posedge clock)
	begin
		// cleared at reset so a read before any write shows known zeros, not unknowns
		if (rst)
		begin
			for (int i = 0; i < MEM_D; i++)
				mem_reg[i] <= '0;
		end
		else if (wr && is_async)
		begin
			if (lane_en[0])
				mem_reg[widx][BYTE_W-1:0] <= din[BYTE_W-1:0];
			if (lane_en[1])
				mem_reg[widx][DATA_W-1:BYTE_W] <= din[DATA_W-1:BYTE_W];
		end
	end

	// ---------------------------------------------------------------
	// read path and lane drive
	// ---------------------------------------------------------------
	// data follows the address each clock, so low-bit page steps need no new strobe
	always_ff @(posedge clock)
	begin
		if (rst)
			data_out <= '0;
		else
			data_out <= mem_reg[widx];
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			data_oe <= 2'h0;
		else if (rd && is_async)
			data_oe <= lane_en;
		else
			data_oe <= 2'h0;
	end

	// wait never driven in this mode
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			wait_out <= 1'b0;
			wait_oe  <= 1'b0;
		end
		else
		begin
			wait_out <= 1'b0;
			wait_oe  <= 1'b0;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			standby     <= 1'b1;
			async_mode  <= 1'b1;
			power_ready <= 1'b0;
		end
		else
		begin
			standby     <= !sel;
			async_mode  <= is_async;
			power_ready <= (pwr_reg == PSAB_READY);
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	deselect_float_a: assert property (@(posedge clock) disable iff (rst)
		!sel |=> data_oe == 2'h0) else $error("lanes driven while deselected");
	idle_float_a: assert property (@(posedge clock) disable iff (rst)
		(sel && (lane_en == 2'h0)) |=> data_oe == 2'h0) else $error("lanes driven, no byte enable");
	read_lanes_a: assert property (@(posedge clock) disable iff (rst)
		(rd && is_async) |=> data_oe == $past(lane_en)) else $error("read lanes wrong");
	write_store_a: assert property (@(posedge clock) disable iff (rst)
		(wr && is_async && lane_en[0]) |=> mem_reg[$past(widx)][7:0] == $past(din[7:0]))
		else $error("lower byte not stored");
	wait_float_a: assert property (@(posedge clock) disable iff (rst)
		!wait_oe) else $error("wait driven");
	mode_write_a: assert property (@(posedge clock) disable iff (rst)
		(mrs_hit && !mrs_d_reg) |=> mode_reg == $past(addr[MODE_W-1:0]))
		else $error("mode register not written");
	async_flag_a: assert property (@(posedge clock) disable iff (rst)
		##1 async_mode == $past(mode_reg[MS_HI:MS_LO] == MS_ASYNC)) else $error("mode flag wrong");
	page_read_a: assert property (@(posedge clock) disable iff (rst)
		1'b1 |=> data_out == $past(mem_reg[widx])) else $error("page data wrong");
	default_mode_a: assert property (@(posedge clock)
		rst |=> async_mode && mode_reg == MODE_RST) else $error("reset mode not async");
	ready_order_a: assert property (@(posedge clock) disable iff (rst)
		(pwr_reg == PSAB_POWER_UP) |=> pwr_reg != PSAB_READY) else $error("ready skipped settle");

endmodule : psab_bus

/* verif/psab_host.sv */
// psab_host: host memory controller driving the async pins of the ram
// assumes one clock; pins change 1 ns after a rising edge
`timescale 1ns/1ps
module psab_host
	import psab_pkg::*;
(
	input  wire logic          clock,
	output psab_ctl_t          ctl_pins,
	output logic [ADDR_W-1:0]  address,
	output logic [DATA_W-1:0]  data_in,
	output logic               link_clock_pin
);
	// ---------------------------------------------------------------
	// pin drivers
	// ---------------------------------------------------------------
	// every pin holds a valid level from time zero, never floating
	initial
	begin
		ctl_pins       = psab_ctl_t'(6'h3F);
		address        = '0;
		data_in        = '0;
		link_clock_pin = 1'b0;
	end

	// select held high for n edges: power-up wait
	task automatic idle(input int n);
		@(posedge clock);
		#1 ctl_pins = psab_ctl_t'(6'h3F);
		repeat (n) @(posedge clock);
	endtask : idle

	// one access held four edges, so the two-flop sync and decode settle
	task automatic access(input logic [5:0] ctl, input logic [ADDR_W-1:0] addr,
		input logic [DATA_W-1:0] wdata);
		@(posedge clock);
		#1;
		ctl_pins = psab_ctl_t'(ctl);
		address  = addr;
		// released bus shows the inverse of its last value, not a stale copy
		data_in  = ctl[3] ? ~data_in : wdata;
		repeat (4)
		begin
			@(posedge clock);
			#1 link_clock_pin = ~link_clock_pin;
		end
	endtask : access
endmodule : psab_host

/* verif/testbench.sv */
// testbench: scenarios for the async pin behaviour of the ram
// assumes psab_host drives the pins; outputs read 4 edges after a change
`timescale 1ns/1ps
module testbench;
	import psab_pkg::*;
	logic              clock;
	logic              rst;
	psab_ctl_t         ctl_pins;
	logic [ADDR_W-1:0] address;
	logic [DATA_W-1:0] data_in;
	logic              link_clock_pin;
	logic [DATA_W-1:0] data_out;
	logic [1:0]        data_oe;
	logic              wait_out;
	logic              wait_oe;
	logic              standby;
	logic              async_mode;
	logic              power_ready;
	int                n_mismatch;
	int                tests_run;

	psab_bus i_psab_bus (.clock(clock), .rst(rst), .ctl_pins(ctl_pins), .address(address),
		.data_in(data_in), .link_clock_pin(link_clock_pin), .data_out(data_out),
		.data_oe(data_oe), .wait_out(wait_out), .wait_oe(wait_oe), .standby(standby),
		.async_mode(async_mode), .power_ready(power_ready));
	psab_host i_psab_host (.clock(clock), .ctl_pins(ctl_pins), .address(address),
		.data_in(data_in), .link_clock_pin(link_clock_pin));

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic summarize;
		if (n_mismatch == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize

	// read: lanes checked, data only on driven lanes (floating lanes hold garbage)
	task automatic rd(input logic [5:0] c, input int a, input logic [1:0] oe,
		input logic [15:0] exp);
		i_psab_host.access(c, 21'(a), 16'h0000);
		chk("lanes", {14'h0000, data_oe}, {14'h0000, oe});
		chk("data", data_out & {{8{oe[1]}}, {8{oe[0]}}}, exp & {{8{oe[1]}}, {8{oe[0]}}});
	endtask : rd

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset;
		chk("standby", 16'(standby), 16'h0001);
		chk("async", 16'(async_mode), 16'h0001);
		chk("wait", {14'h0000, wait_oe, wait_out}, 16'h0000);
		chk("lanes", {14'h0000, data_oe}, 16'h0000);
	endtask : t_reset

	task automatic t_powerup;
		i_psab_host.idle(PWRUP_CYC + 4);
		chk("ready", 16'(power_ready), 16'h0000);
		rd(6'h19, 0, 2'h0, 16'h0000);
		chk("ready", 16'(power_ready), 16'h0001);
		i_psab_host.access(6'h10, 21'h000000, 16'h0000);
		chk("async", 16'(async_mode), 16'h0001);
	endtask : t_powerup

	// word writes, byte writes, then a page walk on the two low bits
	task automatic t_write_page;
		for (int i = 0; i < 4; i++)
			i_psab_host.access(6'h11, 21'(4 + i), 16'h1111 * 16'(i + 1));
		i_psab_host.access(6'h13, 21'h000005, 16'hFFC3);
		i_psab_host.access(6'h15, 21'h000006, 16'h9AFF);
		i_psab_host.access(6'h17, 21'h000004, 16'h0000);
		rd(6'h09, 4, 2'h3, 16'h1111);
		rd(6'h09, 5, 2'h3, 16'h22C3);
		rd(6'h09, 6, 2'h3, 16'h9A33);
		rd(6'h08, 7, 2'h3, 16'h4444);
		rd(6'h0B, 5, 2'h1, 16'h22C3);
		rd(6'h0D, 6, 2'h2, 16'h9A33);
	endtask : t_write_page

	task automatic t_float;
		rd(6'h0F, 4, 2'h0, 16'h0000);
		rd(6'h29, 4, 2'h0, 16'h0000);
		chk("standby", 16'(standby), 16'h0001);
		chk("wait", {14'h0000, wait_oe, wait_out}, 16'h0000);
	endtask : t_float

	// another mode select refuses async reads until mode 00 returns
	task automatic t_mode;
		i_psab_host.access(6'h10, 21'h004000, 16'h0000);
		chk("async", 16'(async_mode), 16'h0000);
		rd(6'h09, 4, 2'h0, 16'h0000);
		i_psab_host.access(6'h10, 21'h000000, 16'h0000);
		chk("async", 16'(async_mode), 16'h0001);
		rd(6'h09, 4, 2'h3, 16'h1111);
	endtask : t_mode

	// ---------------------------------------------------------------
	// main sequence and watchdog
	// ---------------------------------------------------------------
	initial
	begin
		n_mismatch = 0;
		tests_run  = 0;
		rst        = 1'b1;
		repeat (3) @(posedge clock);
		#1 rst = 1'b0;
		t_reset();
		t_powerup();
		t_write_page();
		t_float();
		t_mode();
		summarize();
	end

	// a hang costs a mismatch, then the normal closing
	initial
	begin
		repeat (PWRUP_CYC + 5000) @(posedge clock);
		n_mismatch++;
		summarize();
	end
endmodule : testbench
